//--- psd_pkg.sv
// Package with register map, field positions, reset values and timing.
package psd_pkg;
    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [11:0] ADDR_DMA_COMMAND = 12'h230;
    localparam logic [11:0] ADDR_BYTE_COUNT = 12'h234;
    localparam logic [11:0] ADDR_PORT_SETUP = 12'h238;
    localparam logic [11:0] ADDR_POLARITY = 12'h23C;
    localparam logic [11:0] ADDR_IRQ_REASON = 12'h250;
    // ********************************************************************
    // Fields and reset values
    // ********************************************************************
    localparam int SETUP_WIDTH_BIT = 0;
    localparam int SETUP_MODE_LO = 2;
    localparam int SETUP_CNT_DIS_BIT = 7;
    localparam int POL_REQ_BIT = 2;
    localparam int POL_ACK_BIT = 3;
    localparam int REASON_DONE_BIT = 8;
    localparam int REASON_STOP_BIT = 12;
    localparam logic [31:0] BYTE_COUNT_RESET = 32'h0000_0000;
    localparam logic [15:0] PORT_SETUP_RESET = 16'h0001;
    localparam logic [7:0] POLARITY_RESET = 8'h04;
    localparam logic [1:0] MODE_STROBE = 2'h0;
    // ********************************************************************
    // Commands
    // ********************************************************************
    localparam logic [7:0] CMD_BUS_TO_EP = 8'h00;
    localparam logic [7:0] CMD_EP_TO_BUS = 8'h01;
    localparam logic [7:0] CMD_STOP = 8'h13;
    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLOCK_MHZ = 200;
    localparam int STAGE_DELAY_NS = 60;
    localparam int STAGE_DELAY_CYC = (STAGE_DELAY_NS * CLOCK_MHZ) / 1000;
    localparam int STAGE_BYTES = 8;
    typedef enum logic [1:0] {PSD_IDLE, PSD_IN, PSD_OUT} psd_state_e;
endpackage

//--- psd_stage.sv
// Staging buffer of up to eight bytes between DMA bus and endpoint buffer.
`timescale 1ns/10ps
module psd_stage
    import psd_pkg::*;
#(
    parameter int BYTES = STAGE_BYTES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic load,
    input wire logic [31:0] load_data,
    input wire logic [2:0] load_bytes,
    input wire logic unload,
    output logic [7:0] unload_data,
    output logic [3:0] level,
    output logic empty,
    output logic room4
);
    logic [7:0] mem [BYTES];
    logic [2:0] rd_ptr;
    logic [2:0] wr_ptr;
    logic [3:0] count;
    logic [3:0] next_count;

    assign unload_data = mem[rd_ptr];
    assign level = count;
    assign empty = (count == 4'h0);
    assign room4 = (count <= 4'(BYTES - 4));

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = next_count + {1'b0, load_bytes};
        end
        if (unload && !empty) begin
            next_count = next_count - 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || flush) begin
            count <= 4'h0;
            rd_ptr <= 3'h0;
            wr_ptr <= 3'h0;
        end else begin
            count <= next_count;
            if (unload && !empty) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            if (load) begin
                wr_ptr <= wr_ptr + load_bytes;
            end
        end
    end

    // Each entry picks its own byte lane, so every entry has one writer.
    genvar i;
    generate
        for (i = 0; i < BYTES; i++) begin : g_entry
            logic [2:0] lane;
            assign lane = 3'(i) - wr_ptr;
            always_ff @(posedge clock) begin
                if (load && (lane < load_bytes)) begin
                    mem[i] <= load_data[8*lane[1:0] +: 8];
                end
            end
        end
    endgenerate
endmodule

//--- psd_top.sv
// Setup registers and strobe datapath of the slave generic DMA port.
//
// Notes on behaviour
// - A 32-bit byte counter is loaded with the length and reads back what remains.
// - Software reaches the counter as four byte lanes, bits 7:0 lowest.
// - IN data waits in an eight-byte stage and drains to the endpoint in 60 ns.
// - OUT endpoint data stays valid until the read strobe has latched it for the bus.
// - Setup bit 7 set stops the counter from governing the transfer.
// - In mode 00 the write strobe latches bus data and the read strobe drives it.
// - Setup bit 0 picks 32-bit (0) or 16-bit (1) width and resets to 1.
// - Polarity bit 3 makes acknowledge active high when 1, resets to 0.
// - Polarity bit 2 makes request active high when 1, resets to 1.
// - Command 00h moves bus data to the endpoint, 01h endpoint data to the bus.
// - Reaching a zero count sets a done flag that a written 1 clears.
`timescale 1ns/10ps
module psd_top
    import psd_pkg::*;
#(
    parameter int EP_DEPTH = 64
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic bus_reset,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0] reg_be,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic dma_request,
    input wire logic dma_ack,
    input wire logic dma_wr_n,
    input wire logic dma_rd_n,
    input wire logic [31:0] dma_data_in,
    output logic [31:0] dma_data_out,
    output logic dma_data_oe,
    output logic [31:0] ep_wdata,
    output logic ep_wvalid,
    input wire logic [31:0] ep_rdata,
    input wire logic ep_rvalid,
    output logic ep_rtake,
    output logic ep_clear
);
    // ********************************************************************
    // Registers
    // ********************************************************************
    logic [31:0] remaining_byte_count;
    logic [15:0] dma_port_setup;
    logic [7:0] dma_handshake_polarity;
    logic [15:0] irq_reason;
    psd_state_e state;
    logic wr_q;
    logic rd_q;
    logic clr_all;

    logic counter_disable;
    logic ack_polarity;
    logic request_polarity;
    logic width16;
    logic mode_ok;
    logic ack_active;
    logic wr_edge;
    logic rd_edge;
    logic [2:0] word_bytes;
    logic [31:0] bytes_moved;
    logic [31:0] count_less;
    logic count_hit;
    logic cmd_write;
    logic stage_empty;
    logic stage_room;
    logic [7:0] stage_byte;
    logic stage_unload;

    assign clr_all = sys_rst || bus_reset;
    assign counter_disable = dma_port_setup[SETUP_CNT_DIS_BIT];
    assign width16 = dma_port_setup[SETUP_WIDTH_BIT];
    assign mode_ok = (dma_port_setup[SETUP_MODE_LO +: 2] == MODE_STROBE);
    assign ack_polarity = dma_handshake_polarity[POL_ACK_BIT];
    assign request_polarity = dma_handshake_polarity[POL_REQ_BIT];
    assign ack_active = (dma_ack == ack_polarity);
    assign word_bytes = width16 ? 3'h2 : 3'h4;
    assign cmd_write = reg_write && (reg_addr == ADDR_DMA_COMMAND);
    // Strobe edges: the write strobe falls to latch, read strobe to drive.
    assign wr_edge = mode_ok && ack_active && !dma_wr_n && wr_q;
    assign rd_edge = mode_ok && ack_active && !dma_rd_n && rd_q;

    always_comb begin
        bytes_moved = 32'h0;
        if ((state == PSD_IN && wr_edge && stage_room) ||
            (state == PSD_OUT && rd_edge && ep_rvalid)) begin
            bytes_moved = {29'h0, word_bytes};
        end
    end

    assign count_hit = !counter_disable && (bytes_moved != 32'h0) &&
        (remaining_byte_count <= bytes_moved);
    assign count_less = remaining_byte_count - bytes_moved;

    always_ff @(posedge clock) begin
        wr_q <= dma_wr_n;
        rd_q <= dma_rd_n;
    end

    // ********************************************************************
    // Byte counter
    // ********************************************************************
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_cnt_lane
            always_ff @(posedge clock) begin
                if (clr_all) begin
                    remaining_byte_count[8*i +: 8] <=
                        BYTE_COUNT_RESET[8*i +: 8];
                end else if (reg_write && reg_addr == ADDR_BYTE_COUNT &&
                             reg_be[i]) begin
                    remaining_byte_count[8*i +: 8] <=
                        reg_wdata[8*i +: 8];
                end else if (!counter_disable) begin
                    remaining_byte_count[8*i +: 8] <= count_hit ? 8'h00 :
                        count_less[8*i +: 8];
                end
            end
        end
    endgenerate

    // ********************************************************************
    // Setup and polarity registers
    // ********************************************************************
    always_ff @(posedge clock) begin
        if (clr_all) begin
            dma_port_setup <= PORT_SETUP_RESET;
        end else if (reg_write && reg_addr == ADDR_PORT_SETUP) begin
            if (reg_be[0]) begin
                dma_port_setup[7:0] <= reg_wdata[7:0];
            end
            if (reg_be[1]) begin
                dma_port_setup[15:8] <= reg_wdata[15:8];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (clr_all) begin
            dma_handshake_polarity <= POLARITY_RESET;
        end else if (reg_write && reg_addr == ADDR_POLARITY && reg_be[0]) begin
            dma_handshake_polarity <= reg_wdata[7:0];
        end
    end

    // ********************************************************************
    // Transfer state
    // ********************************************************************
    always_ff @(posedge clock) begin
        if (clr_all) begin
            state <= PSD_IDLE;
        end else if (cmd_write && reg_be[0]) begin
            unique case (reg_wdata[7:0])
                CMD_BUS_TO_EP: state <= PSD_IN;
                CMD_EP_TO_BUS: state <= PSD_OUT;
                CMD_STOP: state <= PSD_IDLE;
                default: state <= state;
            endcase
        end else if (count_hit) begin
            state <= PSD_IDLE;
        end
    end

    // The done flag set wins over a clear written in the same cycle.
    always_ff @(posedge clock) begin
        if (clr_all) begin
            irq_reason <= 16'h0000;
        end else begin
            if (reg_write && reg_addr == ADDR_IRQ_REASON && reg_be[1]) begin
                irq_reason[15:8] <= irq_reason[15:8] & ~reg_wdata[15:8];
            end
            if (count_hit) begin
                irq_reason[REASON_DONE_BIT] <= 1'b1;
            end
            if (cmd_write && reg_be[0] && reg_wdata[7:0] == CMD_STOP) begin
                irq_reason[REASON_STOP_BIT] <= 1'b1;
            end
        end
    end

    // ********************************************************************
    // Request line and OUT path
    // ********************************************************************
    assign dma_request = (state != PSD_IDLE &&
        (counter_disable || remaining_byte_count != 32'h0)) ==
        request_polarity;

    always_ff @(posedge clock) begin
        if (clr_all) begin
            dma_data_out <= 32'h0;
            dma_data_oe <= 1'b0;
        end else begin
            dma_data_oe <= (state == PSD_OUT) && mode_ok && ack_active &&
                !dma_rd_n;
            if (rd_edge && ep_rvalid) begin
                dma_data_out <= width16 ? {16'h0, ep_rdata[15:0]} : ep_rdata;
            end
        end
    end

    // Endpoint data is only consumed once it has gone onto the bus.
    assign ep_rtake = (state == PSD_OUT) && rd_edge && ep_rvalid;
    assign ep_clear = 1'b0;

    // ********************************************************************
    // IN staging path
    // ********************************************************************
    psd_stage #(
        .BYTES(STAGE_BYTES)
    ) u_stage (
        .clock(clock),
        .sys_rst(clr_all),
        .flush(1'b0),
        .load((state == PSD_IN) && wr_edge && stage_room),
        .load_data(dma_data_in),
        .load_bytes(word_bytes),
        .unload(stage_unload),
        .unload_data(stage_byte),
        .level(),
        .empty(stage_empty),
        .room4(stage_room)
    );

    // One byte drains per cycle, so eight bytes leave within the limit.
    assign stage_unload = !stage_empty;

    always_ff @(posedge clock) begin
        if (clr_all) begin
            ep_wdata <= 32'h0;
            ep_wvalid <= 1'b0;
        end else begin
            ep_wvalid <= !stage_empty;
            ep_wdata <= {24'h0, stage_byte};
        end
    end

    // ********************************************************************
    // Register read port
    // ********************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_read) begin
            unique case (reg_addr)
                ADDR_BYTE_COUNT: reg_rdata <= remaining_byte_count;
                ADDR_PORT_SETUP: reg_rdata <= {16'h0, dma_port_setup};
                ADDR_POLARITY: reg_rdata <= {24'h0, dma_handshake_polarity};
                ADDR_IRQ_REASON: reg_rdata <= {16'h0, irq_reason};
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule

//--- psd_assertions.sv
// Checker of the setup registers and the strobe port.
`timescale 1ns/10ps
module psd_assertions
    import psd_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic bus_reset,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0] reg_be,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic dma_request,
    input wire logic dma_wr_n,
    input wire logic dma_rd_n,
    input wire logic [31:0] dma_data_out,
    input wire logic dma_data_oe,
    input wire logic ep_clear
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_count_rw;
        (reg_write && reg_addr == ADDR_BYTE_COUNT && reg_be == 4'hF
            && dma_wr_n && dma_rd_n && !bus_reset)
            ##1 (!reg_write && !bus_reset && dma_wr_n && dma_rd_n)
            ##1 (reg_read && !reg_write && reg_addr == ADDR_BYTE_COUNT)
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_count_rw: assert property (p_count_rw)
        else $error("count read back differs from write");
    property p_pol_rw;
        (reg_write && reg_addr == ADDR_POLARITY && reg_be[0] && !bus_reset)
            ##1 (!reg_write && !bus_reset)
            ##1 (reg_read && !reg_write && reg_addr == ADDR_POLARITY)
            |=> reg_rdata[3:2] == $past(reg_wdata[3:2], 3);
    endproperty
    a_pol_rw: assert property (p_pol_rw)
        else $error("polarity bits read back differ");
    property p_setup_reset;
        bus_reset ##1 (reg_read && !reg_write && reg_addr == ADDR_PORT_SETUP)
            |=> reg_rdata[15:0] == PORT_SETUP_RESET;
    endproperty
    a_setup_reset: assert property (p_setup_reset)
        else $error("setup not at reset value after bus reset");
    property p_pol_reset;
        bus_reset ##1 (!reg_write && !bus_reset) [*2]
            ##1 (reg_read && !reg_write && reg_addr == ADDR_POLARITY)
            |=> reg_rdata[7:0] == POLARITY_RESET;
    endproperty
    a_pol_reset: assert property (p_pol_reset)
        else $error("polarity not at reset value after bus reset");
    property p_oe_on_read;
        dma_data_oe |-> !$past(dma_rd_n);
    endproperty
    a_oe_on_read: assert property (p_oe_on_read)
        else $error("data driven without read strobe");
    property p_out_on_read;
        $changed(dma_data_out) && !$past(bus_reset) |-> !$past(dma_rd_n);
    endproperty
    a_out_on_read: assert property (p_out_on_read)
        else $error("bus data changed without read strobe");
    property p_no_clear;
        !ep_clear;
    endproperty
    a_no_clear: assert property (p_no_clear)
        else $error("endpoint buffer cleared");
    property p_idle_request;
        $fell(bus_reset) |-> !dma_request;
    endproperty
    a_idle_request: assert property (p_idle_request)
        else $error("request active after bus reset");
endmodule
bind psd_top psd_assertions i_chk (.clock, .sys_rst, .bus_reset,
    .reg_addr, .reg_wdata, .reg_be, .reg_write, .reg_read, .reg_rdata,
    .dma_request, .dma_wr_n, .dma_rd_n, .dma_data_out, .dma_data_oe,
    .ep_clear);

//--- psd_dma_model.sv
// Behavioural external DMA controller strobing the slave port.
`timescale 1ns/10ps
module psd_dma_model (
    input wire logic clock,
    input wire logic en,
    input wire logic dir_out,
    input wire logic slow,
    input wire logic req_pol,
    input wire logic ack_pol,
    input wire logic [7:0] budget,
    input wire logic dma_request,
    output logic dma_ack = 1'b1,
    output logic dma_wr_n = 1'b1,
    output logic dma_rd_n = 1'b1,
    output logic [31:0] dma_data_in = 32'h0,
    output logic [7:0] done = 8'h0
);
    logic [1:0] gap = 2'h0;
    // Data lines carry a fresh word every cycle, so stale data is not kept.
    always @(posedge clock) begin
        dma_data_in <= $urandom;
        if (!en) begin
            done <= 8'h0;
            gap <= 2'h0;
            dma_ack <= !ack_pol;
            dma_wr_n <= 1'b1;
            dma_rd_n <= 1'b1;
        end else if (!dma_wr_n || !dma_rd_n) begin
            dma_wr_n <= 1'b1;
            dma_rd_n <= 1'b1;
            done <= done + 8'h1;
            gap <= slow ? 2'h3 : 2'h0;
        end else if (gap != 2'h0) begin
            gap <= gap - 2'h1;
        end else if (done < budget && dma_request == req_pol) begin
            dma_ack <= ack_pol;
            if (dir_out) begin
                dma_rd_n <= 1'b0;
            end else begin
                dma_wr_n <= 1'b0;
            end
        end
    end
endmodule

//--- test_peripheral_slave_dma_setup.sv
// Self-checking bench for the slave DMA setup port.
`timescale 1ns/10ps
module test_peripheral_slave_dma_setup
    import psd_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic bus_reset = 1'b0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [3:0] reg_be = 4'h0;
    logic [31:0] ep_rdata = 32'h0;
    logic ep_rvalid = 1'b1;
    logic en = 1'b0;
    logic dir_out = 1'b0;
    logic slow = 1'b0;
    logic [1:0] pol = 2'b01;
    logic [7:0] budget = 8'h0;
    logic [7:0] done;
    logic [31:0] reg_rdata, dma_data_in, dma_data_out, ep_wdata, r, v, m;
    logic dma_request, dma_ack, dma_wr_n, dma_rd_n, dma_data_oe;
    logic ep_wvalid, ep_rtake, ep_clear;
    int mismatches = 0;
    int n_compared = 0;
    int n_ep = 0;
    int n_take = 0;
    logic w16 = 1'b0;
    logic [7:0] exp_q [$];
    psd_top i_dut (.clock, .sys_rst, .bus_reset, .reg_addr, .reg_wdata,
        .reg_be, .reg_write, .reg_read, .reg_rdata, .dma_request, .dma_ack,
        .dma_wr_n, .dma_rd_n, .dma_data_in, .dma_data_out, .dma_data_oe,
        .ep_wdata, .ep_wvalid, .ep_rdata, .ep_rvalid, .ep_rtake, .ep_clear);
    psd_dma_model i_far (.clock, .en, .dir_out, .slow, .budget,
        .req_pol(pol[0]), .ack_pol(pol[1]), .dma_request, .dma_ack,
        .dma_wr_n, .dma_rd_n, .dma_data_in, .done);
    initial begin
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (ep_wvalid) begin
            n_ep <= n_ep + 1;
            check("ep byte", ep_wdata, {24'h0, exp_q.pop_front()});
        end
        if (ep_rtake) begin
            n_take <= n_take + 1;
        end
        if (en && !dma_wr_n) begin
            for (int b = 0; b < (w16 ? 2 : 4); b++) begin
                exp_q.push_back(dma_data_in[8*b +: 8]);
            end
        end
    end
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] be);
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= be;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask
    function automatic logic [31:0] left(input logic [31:0] n,
            input int k, input logic w16);
        logic [31:0] step;
        step = w16 ? 32'h2 : 32'h4;
        return (n > k * step) ? n - k * step : 32'h0;
    endfunction
    task automatic run(input logic [7:0] cmd, input logic [15:0] setup,
            input logic [31:0] n, input int k);
        int t;
        wr(ADDR_POLARITY, {28'h0, pol, 2'b00}, 4'h1);
        rd(ADDR_POLARITY, r);
        check("polarity", r, {28'h0, pol, 2'b00});
        #1 check("idle request", {31'h0, dma_request}, {31'h0, !pol[0]});
        @(posedge clock);
        wr(ADDR_PORT_SETUP, {16'h0, setup}, 4'h3);
        wr(ADDR_BYTE_COUNT, n, 4'hF);
        rd(ADDR_BYTE_COUNT, r);
        check("count load", r, n);
        n_ep = 0;
        n_take = 0;
        w16 = setup[0];
        ep_rdata <= $urandom;
        wr(ADDR_DMA_COMMAND, {24'h0, cmd}, 4'h1);
        dir_out <= cmd[0];
        budget <= k[7:0];
        en <= 1'b1;
        for (t = 0; t < 400 && done !== k[7:0]; t++) begin
            @(posedge clock);
        end
        en <= 1'b0;
        repeat (STAGE_DELAY_CYC + 2) @(posedge clock);
        rd(ADDR_BYTE_COUNT, r);
        check("count left", r, setup[7] ? n : left(n, k, setup[0]));
        rd(ADDR_IRQ_REASON, r);
        check("done", {31'h0, r[REASON_DONE_BIT]}, {31'h0, !setup[7]});
        check("ep bytes", n_ep, cmd[0] ? 0 : k * (setup[0] ? 2 : 4));
        check("ep takes", n_take, cmd[0] ? k : 0);
        if (cmd[0]) begin
            check("bus data", dma_data_out, ep_rdata);
        end
        wr(ADDR_DMA_COMMAND, {24'h0, CMD_STOP}, 4'h1);
        wr(ADDR_IRQ_REASON, 32'h0000_1100, 4'h3);
        rd(ADDR_IRQ_REASON, r);
        check("reason clear", r, 32'h0);
    endtask
    initial begin
        void'($urandom(32'h9FCC));
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rd(ADDR_BYTE_COUNT, r);
        check("count reset", r, BYTE_COUNT_RESET);
        rd(ADDR_PORT_SETUP, r);
        check("setup reset", r, {16'h0, PORT_SETUP_RESET});
        rd(ADDR_POLARITY, r);
        check("polarity reset", r, {24'h0, POLARITY_RESET});
        rd(12'h300, r);
        check("unmapped", r, 32'h0);
        v = $urandom;
        for (int k = 0; k < 4; k++) begin
            m = 32'hFF << (8 * k);
            wr(ADDR_BYTE_COUNT, ($urandom & ~m) | (v & m), 4'h1 << k);
        end
        rd(ADDR_BYTE_COUNT, r);
        check("count lanes", r, v);
        for (int i = 0; i < 4; i++) begin
            pol <= i[1:0];
            slow <= (i == 1);
            @(posedge clock);
            case (i)
                0: run(CMD_BUS_TO_EP, 16'h0001, 32'h10, 8);
                1: run(CMD_BUS_TO_EP, 16'h0000, 32'h10, 4);
                2: run(CMD_EP_TO_BUS, 16'h0000, 32'h8, 2);
                default: run(CMD_BUS_TO_EP, 16'h0081, 32'h8, 3);
            endcase
        end
        wr(ADDR_PORT_SETUP, 32'h0000_0080, 4'h3);
        bus_reset <= 1'b1;
        @(posedge clock);
        bus_reset <= 1'b0;
        rd(ADDR_PORT_SETUP, r);
        check("setup bus reset", r, {16'h0, PORT_SETUP_RESET});
        rd(ADDR_POLARITY, r);
        check("polarity bus reset", r, {24'h0, POLARITY_RESET});
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        report_and_stop();
    end
endmodule
